// >>> rtl/blalc_pkg.sv
package blalc_pkg;

  // ----------------------------------------------------------------------
  // Serial port addressing
  // ----------------------------------------------------------------------
  // Device address with the address select pin low
  localparam logic [6:0] DEV_ADDR       = 7'h38;
  // Register select codes carried by the second byte of a command
  localparam logic [7:0] SEL_LED_LEVEL  = 8'h01;
  localparam logic [7:0] SEL_GAIN       = 8'h08;
  localparam logic [7:0] SEL_MIN_LEVEL  = 8'h09;
  localparam logic [7:0] SEL_STEP_CLOCK = 8'h0a;

  // ----------------------------------------------------------------------
  // Register fields, writable masks and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] LED_MASK       = 8'h1f;
  localparam logic [7:0] GAIN_MASK      = 8'h9f;
  localparam logic [7:0] STEP_MASK      = 8'hbf;
  localparam logic [7:0] MIN_MASK       = 8'h0f;
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam int         CODE_MSB       = 4;
  localparam int         GAIN_BIAS_BIT  = 7;
  localparam int         GAIN_MSB       = 4;
  localparam int         TEST_CLK_BIT   = 7;
  localparam int         STEP_SEL_W     = 6;
  localparam int         MIN_MSB        = 3;
  localparam logic [4:0] CODE_TOP       = 5'h1f;
  localparam logic [4:0] CODE_FLOOR     = 5'h01;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int         CLK_PERIOD_NS  = 10;
  localparam int         MS_IN_NS       = 1000000;
  localparam int         MS_CYCLES      = MS_IN_NS / CLK_PERIOD_NS;
  localparam int         MS_CNT_W       = 17;
  localparam logic [10:0] STEP_BASE_MS  = 11'h028;
  localparam int         STEP_CNT_W     = 11;

endpackage

// >>> rtl/blalc_link_if.sv
// Signals passed from the serial-clock side to the system-clock side
interface blalc_link_if;
  logic       busy;      // Toggles at each start, clears at stop
  logic       cfg_tog;   // Toggles after any register write
  logic       led_tog;   // Toggles after a current level write
  logic [7:0] led_level;
  logic [7:0] gain;
  logic [7:0] step_clk;
  logic [7:0] min_level;
  logic       sda_o;
  logic       sda_oe;

  modport link (
    output busy, cfg_tog, led_tog, led_level, gain, step_clk, min_level, sda_o, sda_oe
  );
  modport core (
    input  busy, cfg_tog, led_tog, led_level, gain, step_clk, min_level, sda_o, sda_oe
  );
endinterface

// >>> rtl/blalc_sync.sv
// Two-stage synchroniser for a group of independent levels
module blalc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_reset,
  // Levels
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      meta_reg <= '0;
      o_sync   <= '0;
    end else begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end

endmodule // blalc_sync

// >>> rtl/blalc_link.sv
// Serial port slave running on the serial clock itself
module blalc_link (
  // Pins
  input  wire logic i_scl,
  input  wire logic i_sda,
  input  wire logic i_reset,
  // Towards the core
  blalc_link_if.link lnk
);

  logic       start_tog_reg;
  logic       stop_tog_reg;
  logic       start_seen_reg;
  logic [3:0] bit_cnt_reg;
  logic [1:0] byte_idx_reg;
  logic [7:0] shift_reg;
  logic       match_reg;
  logic       read_reg;
  logic [7:0] sel_reg;
  logic [7:0] led_reg;
  logic [7:0] gain_reg;
  logic [7:0] step_reg;
  logic [7:0] min_reg;
  logic       cfg_tog_reg;
  logic       led_tog_reg;
  logic       oe_reg;

  // ----------------------------------------------------------------------
  // Start and stop detection
  // ----------------------------------------------------------------------
  // Start: data falls while the clock is high
  always_ff @(negedge i_sda or posedge i_reset) begin
    if (i_reset) begin
      start_tog_reg <= 1'b0;
    end else if (i_scl) begin
      start_tog_reg <= ~start_tog_reg;
    end
  end

  // Stop: data rises while the clock is high; catching up ends the command
  always_ff @(posedge i_sda or posedge i_reset) begin
    if (i_reset) begin
      stop_tog_reg <= 1'b0;
    end else if (i_scl) begin
      stop_tog_reg <= start_tog_reg;
    end
  end

  // Start toggle is stable for a full clock low phase before the rising clock reads it
  wire       start_new  = start_tog_reg ^ start_seen_reg;
  wire [7:0] byte_in    = {shift_reg[6:0], i_sda};
  wire       last_bit   = (bit_cnt_reg == 4'h7);
  wire       ack_slot   = (bit_cnt_reg == 4'h8);
  wire       wr_data    = match_reg && !read_reg && (byte_idx_reg == 2'h2);
  wire       rd_phase   = match_reg && read_reg && (byte_idx_reg != 2'h0);
  wire [7:0] rd_data    = (sel_reg == blalc_pkg::SEL_LED_LEVEL)  ? led_reg  :
                          (sel_reg == blalc_pkg::SEL_GAIN)       ? gain_reg :
                          (sel_reg == blalc_pkg::SEL_MIN_LEVEL)  ? min_reg  :
                          (sel_reg == blalc_pkg::SEL_STEP_CLOCK) ? step_reg : 8'h00;
  wire       ack_me     = (byte_idx_reg == 2'h0) ? match_reg : (match_reg && !read_reg);

  // ----------------------------------------------------------------------
  // Byte framing and register writes on the rising clock
  // ----------------------------------------------------------------------
  always_ff @(posedge i_scl or posedge i_reset) begin
    if (i_reset) begin
      start_seen_reg <= 1'b0;
      bit_cnt_reg    <= 4'h0;
      byte_idx_reg   <= 2'h0;
      shift_reg      <= 8'h00;
      match_reg      <= 1'b0;
      read_reg       <= 1'b0;
      sel_reg        <= 8'h00;
      led_reg        <= blalc_pkg::REG_RESET;
      gain_reg       <= blalc_pkg::REG_RESET;
      step_reg       <= blalc_pkg::REG_RESET;
      min_reg        <= blalc_pkg::REG_RESET;
      cfg_tog_reg    <= 1'b0;
      led_tog_reg    <= 1'b0;
    end else if (start_new) begin
      start_seen_reg <= start_tog_reg;
      bit_cnt_reg    <= 4'h1;
      byte_idx_reg   <= 2'h0;
      shift_reg      <= {7'h00, i_sda};
      match_reg      <= 1'b0;
    end else if (ack_slot) begin
      bit_cnt_reg    <= 4'h0;
      if (byte_idx_reg != 2'h2) begin
        byte_idx_reg <= byte_idx_reg + 2'h1;
      end
      if (rd_phase && i_sda) begin
        match_reg    <= 1'b0;                 // Host declined further data
      end
    end else begin
      bit_cnt_reg    <= bit_cnt_reg + 4'h1;
      shift_reg      <= byte_in;
      if (last_bit && byte_idx_reg == 2'h0) begin
        match_reg    <= (byte_in[7:1] == blalc_pkg::DEV_ADDR);
        read_reg     <= byte_in[0];
      end
      if (last_bit && byte_idx_reg == 2'h1 && match_reg && !read_reg) begin
        sel_reg      <= byte_in;
      end
      // Eighth clock of the data byte latches the value
      if (last_bit && wr_data) begin
        cfg_tog_reg  <= ~cfg_tog_reg;
        unique case (sel_reg)
          blalc_pkg::SEL_LED_LEVEL: begin
            led_reg     <= byte_in & blalc_pkg::LED_MASK;
            led_tog_reg <= ~led_tog_reg;
          end
          blalc_pkg::SEL_GAIN:       gain_reg <= byte_in & blalc_pkg::GAIN_MASK;
          blalc_pkg::SEL_STEP_CLOCK: step_reg <= byte_in & blalc_pkg::STEP_MASK;
          blalc_pkg::SEL_MIN_LEVEL:  min_reg  <= byte_in & blalc_pkg::MIN_MASK;
          default: ;                          // Unused selects are ignored
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Data line drive on the falling clock
  // ----------------------------------------------------------------------
  // Acknowledge and read data change only while the clock is low
  always_ff @(negedge i_scl or posedge i_reset) begin
    if (i_reset) begin
      oe_reg <= 1'b0;
    end else if (start_new) begin
      oe_reg <= 1'b0;
    end else if (ack_slot) begin
      oe_reg <= ack_me;
    end else begin
      oe_reg <= rd_phase && !rd_data[3'(4'h7 - bit_cnt_reg)];
    end
  end

  assign lnk.busy      = start_tog_reg ^ stop_tog_reg;
  assign lnk.cfg_tog   = cfg_tog_reg;
  assign lnk.led_tog   = led_tog_reg;
  assign lnk.led_level = led_reg;
  assign lnk.gain      = gain_reg;
  assign lnk.step_clk  = step_reg;
  assign lnk.min_level = min_reg;
  assign lnk.sda_o     = 1'b0;                // Open drain: only ever pulls low
  assign lnk.sda_oe    = oe_reg;

endmodule // blalc_link

// >>> rtl/blalc_top.sv
// Notes on behaviour
// - Current level register loads from the serial data byte; low five bits.
// - New current code reaches the output on the fourth system clock after the data byte's eighth clock.
// - Upper current level bits reserved, read zero; register clears at reset.
// - Each serial start toggles the regulation pause, so a repeated start resumes it; the stop ends it.
// - Up/down counter follows the sensor comparison to move the current code.
// - Regulation never raises the code above the host-programmed maximum.
// - Four-bit minimum field gives a floor; darkness never reaches zero.
// - Counter steps at a selectable slow rate for smooth brightness change.
// - Five-bit host gain setting scales the sensor current.
// - One-hot select bits give 40 to 1280 ms per step.
// - Test clock bit jumps straight to the end value; host can set it with a step clock write.
// - Current falls step by step when sensed light is below the target.
// - Rising and falling use the same step period.
// - Five-bit code is a log scale, zero at 00, full current at 1F.
module blalc_top #(
  parameter int unsigned CYCLES_PER_MS = blalc_pkg::MS_CYCLES
) (
  // System clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_reset,
  // Serial port pins
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda,
  output logic            o_sda_oe,
  // Ambient sensor comparison, high when more current is wanted
  input  wire logic       i_ambient_sense_input,
  // Backlight controls
  output logic [4:0]      o_current_code,
  output logic            o_sensor_bias_switch,
  output logic [4:0]      o_photo_gain,
  output logic            o_regulating
);

  // ----------------------------------------------------------------------
  // Serial port on its own clock
  // ----------------------------------------------------------------------
  blalc_link_if link_if ();

  blalc_link i_blalc_link (
    .i_scl   (i_scl),
    .i_sda   (i_sda),
    .i_reset (i_reset),
    .lnk     (link_if.link)
  );

  // Pin enable comes straight from a falling-edge flop in the link; the data level is a constant low
  assign o_sda    = link_if.sda_o;
  assign o_sda_oe = link_if.sda_oe;

  // ----------------------------------------------------------------------
  // Crossing into the system clock
  // ----------------------------------------------------------------------
  logic [3:0] sync_out;

  blalc_sync #(
    .WIDTH (4)
  ) i_blalc_sync (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .i_async ({i_ambient_sense_input, link_if.led_tog, link_if.cfg_tog, link_if.busy}),
    .o_sync  (sync_out)
  );

  wire busy_s  = sync_out[0];
  wire cfg_s   = sync_out[1];
  wire led_s   = sync_out[2];
  wire sense_s = sync_out[3];

  logic       cfg_seen_reg;
  logic       led_seen_reg;
  logic       led_load_reg;
  logic [7:0] led_sh_reg;
  logic [7:0] gain_sh_reg;
  logic [7:0] step_sh_reg;
  logic [7:0] min_sh_reg;

  // Toggle edges mark completed writes; register words are long settled by then
  wire cfg_new = cfg_s ^ cfg_seen_reg;
  wire led_new = led_s ^ led_seen_reg;

  // Shadow copies of the serial-side registers
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      cfg_seen_reg <= 1'b0;
      led_seen_reg <= 1'b0;
      led_load_reg <= 1'b0;
      led_sh_reg   <= blalc_pkg::REG_RESET;
      gain_sh_reg  <= blalc_pkg::REG_RESET;
      step_sh_reg  <= blalc_pkg::REG_RESET;
      min_sh_reg   <= blalc_pkg::REG_RESET;
    end else begin
      cfg_seen_reg <= cfg_s;
      led_seen_reg <= led_s;
      led_load_reg <= led_new;
      if (cfg_new || led_new) begin
        led_sh_reg  <= link_if.led_level;
        gain_sh_reg <= link_if.gain;
        step_sh_reg <= link_if.step_clk;
        min_sh_reg  <= link_if.min_level;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Decoded controls
  // ----------------------------------------------------------------------
  // Maximum is the host current code; floor never below code one
  wire [4:0] max_code   = led_sh_reg[blalc_pkg::CODE_MSB:0];
  wire [4:0] min_field  = {1'b0, min_sh_reg[blalc_pkg::MIN_MSB:0]};
  wire [4:0] floor_code = (min_field > blalc_pkg::CODE_FLOOR) ?
                          min_field : blalc_pkg::CODE_FLOOR;
  wire       photo_on   = gain_sh_reg[blalc_pkg::GAIN_BIAS_BIT];
  wire       run        = photo_on && !busy_s;
  wire       test_clk   = step_sh_reg[blalc_pkg::TEST_CLK_BIT];
  wire [blalc_pkg::STEP_SEL_W-1:0] step_sel = step_sh_reg[blalc_pkg::STEP_SEL_W-1:0];
  wire       step_any   = |step_sel;
  wire       can_rise   = (o_current_code < max_code);
  wire       can_fall   = (o_current_code > floor_code);

  // Lowest set select bit wins; combined selects make no new timing
  logic [blalc_pkg::STEP_CNT_W-1:0] period_ms;
  always_comb begin
    period_ms = blalc_pkg::STEP_BASE_MS;
    for (int i = blalc_pkg::STEP_SEL_W - 1; i >= 0; i--) begin
      if (step_sel[i]) begin
        period_ms = blalc_pkg::STEP_BASE_MS << i;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Slow step clock
  // ----------------------------------------------------------------------
  logic [blalc_pkg::MS_CNT_W-1:0]   ms_cnt_reg;
  logic [blalc_pkg::STEP_CNT_W-1:0] step_cnt_reg;

  localparam logic [blalc_pkg::MS_CNT_W-1:0] MS_LAST =
    blalc_pkg::MS_CNT_W'(CYCLES_PER_MS - 1);

  wire ms_tick   = (ms_cnt_reg == MS_LAST);
  wire step_last = (step_cnt_reg == period_ms - 11'h001);
  wire step_tick = ms_tick && step_last && step_any;

  // Timer restarts whenever regulation stops so every step lasts a whole period
  always_ff @(posedge i_mclk) begin
    if (i_reset || !run || led_load_reg) begin
      ms_cnt_reg   <= '0;
      step_cnt_reg <= '0;
    end else if (ms_tick) begin
      ms_cnt_reg   <= '0;
      step_cnt_reg <= step_last ? '0 : step_cnt_reg + 11'h001;
    end else begin
      ms_cnt_reg   <= ms_cnt_reg + 17'h00001;
    end
  end

  // ----------------------------------------------------------------------
  // Regulation counter
  // ----------------------------------------------------------------------
  // Same period up and down; holds at either bound instead of wrapping
  logic [4:0] code_next;
  always_comb begin
    code_next = o_current_code;
    if (led_load_reg || !photo_on) begin
      code_next = max_code;
    end else if (!run) begin
      code_next = o_current_code;
    end else if (test_clk) begin
      if (floor_code <= max_code) begin
        code_next = sense_s ? max_code : floor_code;
      end
    end else if (step_tick) begin
      if (sense_s && can_rise) begin
        code_next = o_current_code + 5'h01;
      end else if (!sense_s && can_fall) begin
        code_next = o_current_code - 5'h01;
      end
    end
    if (code_next > max_code) begin
      code_next = max_code;
    end
  end

  // Output controls held in flops
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_current_code       <= 5'h00;
      o_sensor_bias_switch <= 1'b0;
      o_photo_gain         <= 5'h00;
      o_regulating         <= 1'b0;
    end else begin
      o_current_code       <= code_next;
      o_sensor_bias_switch <= photo_on;
      o_photo_gain         <= gain_sh_reg[blalc_pkg::GAIN_MSB:0];
      o_regulating         <= run;
    end
  end

endmodule // blalc_top

// >>> test/blalc_top_chk.sv
module blalc_top_chk #(
  parameter int unsigned CYCLES_PER_MS = 10
) (
  // Clock and reset
  input wire logic       i_mclk,
  input wire logic       i_reset,
  // Serial pins
  input wire logic       i_scl,
  input wire logic       i_sda,
  input wire logic       o_sda,
  input wire logic       o_sda_oe,
  // Sensor and backlight
  input wire logic       i_ambient_sense_input,
  input wire logic [4:0] o_current_code,
  input wire logic       o_sensor_bias_switch,
  input wire logic [4:0] o_photo_gain,
  input wire logic       o_regulating
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Step spacing
  // ----------------------------------------------------------------
  localparam int STEP_MIN = 40 * CYCLES_PER_MS - 1;
  logic [4:0]  code_q_reg;
  logic [15:0] gap_reg;
  logic [15:0] gap_next;
  // Saturates so a long quiet spell never wraps back to a short gap
  assign gap_next = (o_current_code != code_q_reg) ? 16'h0000 : gap_reg + {15'h0000, ~&gap_reg};
  always_ff @(posedge i_mclk) begin
    code_q_reg <= o_current_code;
    gap_reg    <= i_reset ? 16'h0000 : gap_next;
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  property p_reset_clear;
    $past(i_reset) |-> o_current_code == 5'h00 && o_photo_gain == 5'h00 && !o_regulating && !o_sda_oe;
  endproperty
  a_reset_clear:
    assert property (p_reset_clear) else $error("outputs not clear after reset");
  property p_bias_gate;
    !o_sensor_bias_switch |-> !o_regulating;
  endproperty
  a_bias_gate:
    assert property (p_bias_gate) else $error("regulating without sensor bias");
  property p_single_step;
    o_regulating && $past(o_regulating) && $changed(o_current_code) |->
      o_current_code == $past(o_current_code) + 5'h01 || o_current_code == $past(o_current_code) - 5'h01;
  endproperty
  a_single_step:
    assert property (p_single_step) else $error("regulation moved more than one step");
  property p_step_gap;
    o_regulating && $past(o_regulating) && $changed(o_current_code) |-> gap_reg >= STEP_MIN;
  endproperty
  a_step_gap:
    assert property (p_step_gap) else $error("regulation steps too close together");
  property p_rise_needs_light;
    o_regulating && $past(o_regulating) && o_current_code > $past(o_current_code) |->
      i_ambient_sense_input || $past(i_ambient_sense_input, 6);
  endproperty
  a_rise_needs_light:
    assert property (p_rise_needs_light) else $error("code rose with sense low");
  property p_fall_needs_dark;
    o_regulating && $past(o_regulating) && o_current_code < $past(o_current_code) |->
      !i_ambient_sense_input || !$past(i_ambient_sense_input, 6);
  endproperty
  a_fall_needs_dark:
    assert property (p_fall_needs_dark) else $error("code fell with sense high");
  property p_pause_on_start;
    i_scl && $past(i_scl) && $fell(i_sda) |-> ##[1:8] !o_regulating;
  endproperty
  a_pause_on_start:
    assert property (p_pause_on_start) else $error("regulation not paused by command");
  property p_gain_quiet;
    $changed(o_photo_gain) || $changed(o_sensor_bias_switch) |-> !o_regulating;
  endproperty
  a_gain_quiet:
    assert property (p_gain_quiet) else $error("gain moved outside a command");
  property p_floor_nonzero;
    o_regulating |-> o_current_code != 5'h00;
  endproperty
  a_floor_nonzero:
    assert property (p_floor_nonzero) else $error("regulated code reached zero");
endmodule // blalc_top_chk

bind blalc_top blalc_top_chk #(.CYCLES_PER_MS(CYCLES_PER_MS)) i_blalc_top_chk (
  .i_mclk(i_mclk), .i_reset(i_reset), .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda),
  .o_sda_oe(o_sda_oe), .i_ambient_sense_input(i_ambient_sense_input),
  .o_current_code(o_current_code), .o_sensor_bias_switch(o_sensor_bias_switch),
  .o_photo_gain(o_photo_gain), .o_regulating(o_regulating));

// >>> test/blalc_host.sv
// Host controller on the serial port; SCL idles high between frames
module blalc_host (
  // Serial pins
  output logic      o_scl,
  output logic      o_sda_low,
  input  wire logic i_sda
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // Data moves only while SCL is low and is read at the rising edge
  task automatic bit_io(input logic b, output logic s);
    o_sda_low = ~b;
    #12 o_scl = 1'b1;
    s = i_sda;
    #24 o_scl = 1'b0;
    #12;
  endtask
  // Also serves as repeated start after an acknowledge clock
  task automatic start();
    #3 o_sda_low = 1'b0;
    #12 o_scl = 1'b1;
    #24 o_sda_low = 1'b1;
    #24 o_scl = 1'b0;
    #12;
  endtask
  task automatic stop();
    o_sda_low = 1'b1;
    #12 o_scl = 1'b1;
    #24 o_sda_low = 1'b0;
    #24;
  endtask
  // A release of 0xff during a read lets the device drive the line
  task automatic xfer(input logic [7:0] tx, input logic ackbit, output logic [7:0] rx,
                      output logic ack_seen);
    for (int k = 7; k >= 0; k--) bit_io(tx[k], rx[k]);
    bit_io(ackbit, ack_seen);
  endtask
endmodule // blalc_host

// >>> test/test_backlight_ambient_light_control.sv
module test_backlight_ambient_light_control;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int          CPM = 10;
  localparam logic [7:0]  WA  = {blalc_pkg::DEV_ADDR, 1'b0};
  // Select, written value, read-back value
  localparam logic [23:0] ROWS [5] = '{24'h01ff1f, 24'h09f303, 24'h0a4101, 24'h087515, 24'h05ff00};
  logic       i_mclk;
  logic       i_reset;
  logic       i_ambient_sense_input;
  logic       o_sda;
  logic       o_sda_oe;
  logic       o_sensor_bias_switch;
  logic       o_regulating;
  logic [4:0] o_current_code;
  logic [4:0] o_photo_gain;
  logic       scl;
  logic       sda_low;
  logic       n;
  logic [7:0] v;
  int         t;
  int         failures;
  int         comparisons;
  wire logic  sda_wire;
  // Pull-up: either party may only pull the line low
  assign sda_wire = ~(sda_low | (o_sda_oe & ~o_sda));
  blalc_top #(.CYCLES_PER_MS(CPM)) i_blalc_top (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_scl(scl), .i_sda(sda_wire), .o_sda(o_sda),
    .o_sda_oe(o_sda_oe), .i_ambient_sense_input(i_ambient_sense_input),
    .o_current_code(o_current_code), .o_sensor_bias_switch(o_sensor_bias_switch),
    .o_photo_gain(o_photo_gain), .o_regulating(o_regulating));
  blalc_host i_blalc_host (.o_scl(scl), .o_sda_low(sda_low), .i_sda(sda_wire));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Settle past the edge so registered outputs are read after they land
  task automatic tick(input int k);
    repeat (k) @(posedge i_mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] sel, input logic [7:0] d);
    logic [7:0] rx;
    logic       x;
    i_blalc_host.start();
    i_blalc_host.xfer(a, 1'b1, rx, n);
    i_blalc_host.xfer(sel, 1'b1, rx, x);
    i_blalc_host.xfer(d, 1'b1, rx, x);
    i_blalc_host.stop();
    tick(8);
  endtask
  task automatic rd(input logic [7:0] sel);
    logic x;
    i_blalc_host.start();
    i_blalc_host.xfer(WA, 1'b1, v, x);
    i_blalc_host.xfer(sel, 1'b1, v, x);
    i_blalc_host.start();
    i_blalc_host.xfer(WA | 8'h01, 1'b1, v, x);
    i_blalc_host.xfer(8'hff, 1'b1, v, x);
    i_blalc_host.stop();
    tick(8);
  endtask
  // Cycles until the current code next moves, bounded
  task automatic wait_step(input int lim);
    logic [4:0] c;
    c = o_current_code;
    t = 0;
    while (o_current_code === c && t < lim) begin
      tick(1);
      t++;
    end
    check("step arrived", t < lim, 1'b1);
  endtask
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  // Limit covers the slowest step periods (about 63000 cycles in all) with margin
  initial begin
    repeat (90000) @(posedge i_mclk);
    failures++;
    summarize();
  end
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    i_reset = 1'b1;
    i_ambient_sense_input = 1'b0;
    failures = 0;
    comparisons = 0;
    repeat (20) @(posedge i_mclk);
    i_reset <= 1'b0;
    tick(2);
    check("code", o_current_code, 5'h00);
    check("sda drive", o_sda, 1'b0);
    check("sda released", o_sda_oe, 1'b0);
    for (int i = 0; i < 4; i++) begin
      rd(ROWS[i][23:16]);
      check("reset value", v, 8'h00);
    end
    $display("reset test done");
    for (int i = 0; i < 5; i++) begin
      wr(WA, ROWS[i][23:16], ROWS[i][15:8]);
      check("address ack", n, 1'b0);
      rd(ROWS[i][23:16]);
      check("read back", v, ROWS[i][7:0]);
    end
    check("code", o_current_code, 5'h1f);
    check("gain", o_photo_gain, 5'h15);
    check("bias", o_sensor_bias_switch, 1'b0);
    wr(8'h72, blalc_pkg::SEL_LED_LEVEL, 8'h02);
    check("foreign address ack", n, 1'b1);
    check("code kept", o_current_code, 5'h1f);
    $display("register test done");
    wr(WA, blalc_pkg::SEL_STEP_CLOCK, 8'h01);
    wr(WA, blalc_pkg::SEL_MIN_LEVEL, 8'h03);
    wr(WA, blalc_pkg::SEL_LED_LEVEL, 8'h10);
    i_ambient_sense_input <= 1'b1;
    wr(WA, blalc_pkg::SEL_GAIN, 8'h80);
    tick(1000);
    check("bias on", o_sensor_bias_switch, 1'b1);
    check("regulating", o_regulating, 1'b1);
    check("held at max", o_current_code, 5'h10);
    i_ambient_sense_input <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      wr(WA, blalc_pkg::SEL_STEP_CLOCK, 8'h01 << i);
      wait_step((2 * 40 * CPM << i) + 500);
      wait_step((2 * 40 * CPM << i) + 500);
      check("step period", t, 40 * CPM << i);
    end
    wr(WA, blalc_pkg::SEL_STEP_CLOCK, 8'h01);
    tick(2000);
    check("floor", o_current_code, 5'h03);
    i_ambient_sense_input <= 1'b1;
    wait_step(1200);
    wait_step(1200);
    check("rise period", t, 40 * CPM);
    tick(5200);
    check("back at max", o_current_code, 5'h10);
    // Test clock lands on the floor in the cycle regulation resumes
    i_ambient_sense_input <= 1'b0;
    wr(WA, blalc_pkg::SEL_STEP_CLOCK, 8'h81);
    check("test clock jump", o_current_code, 5'h03);
    wr(WA, blalc_pkg::SEL_STEP_CLOCK, 8'h01);
    // Code sits at the floor, so dropping the enable must reload the level
    wr(WA, blalc_pkg::SEL_GAIN, 8'h00);
    check("bias off", o_sensor_bias_switch, 1'b0);
    check("code from level", o_current_code, 5'h10);
    $display("regulation test done");
    summarize();
  end
endmodule // test_backlight_ambient_light_control
